//--- hdl/sxp_map.svh
// Notes on behaviour
// - Slave only, clock idle low, sample first.
// - Master drives on falls, device samples rises.
// - Device updates its output bit on falls.
// - Output undriven while select high; frame starts low.
// - First byte: write flag, then 7-bit address.
// - Every data byte travels most significant first.
// - Burst to registers increments address per byte.
// - Queue address stays fixed; bytes go to queue.
// - Select rising ends frame; no address carries over.
// - Single access is a two-byte frame.
// - Write returns the register's previous content.
// - Queue is byte wide, serial-port reachable.
// - Transmit shifter sends queue bytes, MSB first.
// - Receive shifter packs bits into queue bytes.
// - Host waits for switch-done before queue use.
// - Continuous mode passes bits live on data pin.
// - Payload limited to queue, 255, or unlimited.
// - Queue depth fixed at 66 bytes.
// - Full-queue write lost, flags overflow; 1 clears both.
// - Has-bytes indication refreshed when select falls.
`ifndef SXP_MAP_SVH
`define SXP_MAP_SVH

// Queue geometry.
`define SXP_QUEUE_WIDTH 8
`define SXP_QUEUE_DEPTH 66

// Default addresses of the queue port and the status byte.
`define SXP_QUEUE_ADDR 7'h00
`define SXP_STATUS_ADDR 7'h28

// Status byte fields and register reset value.
`define SXP_ST_FULL_BIT 7
`define SXP_ST_HAS_BYTES_BIT 6
`define SXP_ST_OVF_BIT 4
`define SXP_REG_RESET 8'h00

// Payload limits in bytes.
`define SXP_LIMIT_QUEUE 9'h042
`define SXP_LIMIT_MAX 9'h0FF

// Link clock half period in system clocks.
`define SXP_SCK_HALF 4'h8

`endif

//--- hdl/sxp_pkg.sv
package sxp_pkg;

  // Serial port states of the device end.
  typedef enum logic [2:0] {
    SXP_D_IDLE = 3'h1,
    SXP_D_CMD = 3'h2,
    SXP_D_DATA = 3'h4
  } sxp_dev_st_t;

  // Frame states of the host end.
  typedef enum logic [2:0] {
    SXP_H_IDLE = 3'h1,
    SXP_H_RUN = 3'h2,
    SXP_H_END = 3'h4
  } sxp_host_st_t;

  // Payload length limit selection.
  typedef enum logic [1:0] {
    SXP_LEN_QUEUE = 2'h0,
    SXP_LEN_255 = 2'h1,
    SXP_LEN_FREE = 2'h2
  } sxp_len_mode_t;

endpackage

//--- hdl/sxp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sxp_if;
  // Serial link wires; the device output is resolved by its enable.
  logic sck;
  logic nss_b;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Undriven output reads as a pulled-up line.
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (input sck, input nss_b, input mosi, output miso_o, output miso_oe);
  modport host (output sck, output nss_b, output mosi, input miso);
endinterface
`default_nettype wire

//--- hdl/sxp_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxp_map.svh"

// ==========================================================
// Byte queue
module sxp_fifo #(
  parameter int W = `SXP_QUEUE_WIDTH,
  parameter int D = `SXP_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clr,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULLC = CW'(D);

  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  // A write to a full queue is refused here; the caller counts it lost.
  assign o_in_ready = (cnt_q != FULLC);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = i_out_ready & o_out_valid;

  // Storage write.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  // Pointers and fill count; a clear empties the queue at once.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

// ==========================================================
// Device end: serial slave, registers, queue and shifters
module sxp_dev #(
  parameter logic [6:0] QUEUE_ADDR = `SXP_QUEUE_ADDR
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Serial link
  sxp_if.dev bus,
  // Radio side
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  input wire logic i_cont_mode,
  input wire logic i_bit_tick,
  input wire logic i_demod_valid,
  input wire logic i_demod_bit,
  input wire logic i_serial_data_pin,
  input wire logic i_pkt_start,
  input wire logic [1:0] i_len_mode,
  output logic o_mod_bit,
  output logic o_serial_data_pin,
  // Status
  output logic o_queue_has_bytes,
  output logic o_queue_overflow_flag,
  output logic o_queue_full
);
  sxp_pkg::sxp_dev_st_t st_q;
  logic sck_m, sck_s, sck_p, nss_m, nss_s, nss_p, mosi_m, mosi_s;
  logic rise, fall, nss_fall, nss_rise, byte_end;
  logic [2:0] bit_q;
  logic [7:0] in_q, byte_in, out_q, rd_val;
  logic wnr_q, sel_q, rd_ok_q;
  logic [6:0] addr_q;
  logic [7:0] regs [0:127];
  logic spi_push, spi_pop, clr, ovf_q, has_q;
  logic q_ready, q_valid, q_pop;
  logic [7:0] q_head, q_wdata;
  logic rx_push, tx_pop, lim_hit;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic [3:0] tx_left_q;
  logic [2:0] rx_cnt_q;
  logic [8:0] pay_q;

  // ========================================================
  // Link sampling: every pin passes two flops before use.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      {sck_m, sck_s, sck_p} <= 3'h0;
      {nss_m, nss_s, nss_p} <= 3'h7;
      {mosi_m, mosi_s} <= 2'h0;
    end else begin
      {sck_m, sck_s, sck_p} <= {bus.sck, sck_m, sck_s};
      {nss_m, nss_s, nss_p} <= {bus.nss_b, nss_m, nss_s};
      {mosi_m, mosi_s} <= {bus.mosi, mosi_m};
    end
  end

  assign rise = sck_s & ~sck_p & ~nss_s;
  assign fall = ~sck_s & sck_p & ~nss_s;
  assign nss_fall = ~nss_s & nss_p;
  assign nss_rise = nss_s & ~nss_p;
  assign byte_in = {in_q[6:0], mosi_s};
  assign byte_end = rise & (bit_q == 3'h7);

  // ========================================================
  // Frame sequencing: command byte first, data bytes after.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_q <= sxp_pkg::SXP_D_IDLE;
    end else begin
      case (st_q)
        sxp_pkg::SXP_D_IDLE: if (nss_fall) st_q <= sxp_pkg::SXP_D_CMD;
        sxp_pkg::SXP_D_CMD: begin
          if (nss_rise) st_q <= sxp_pkg::SXP_D_IDLE;
          else if (byte_end) st_q <= sxp_pkg::SXP_D_DATA;
        end
        sxp_pkg::SXP_D_DATA: if (nss_rise) st_q <= sxp_pkg::SXP_D_IDLE;
        default: st_q <= sxp_pkg::SXP_D_IDLE;
      endcase
    end
  end

  // Bit count and input shift, most significant bit arriving first.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || nss_fall) begin
      bit_q <= 3'h0;
      in_q <= 8'h00;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      in_q <= byte_in;
    end
  end

  // Command decode and address walk; nothing survives the frame end.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || nss_rise) begin
      wnr_q <= 1'b0;
      addr_q <= 7'h00;
      sel_q <= 1'b0;
    end else if (byte_end && st_q == sxp_pkg::SXP_D_CMD) begin
      wnr_q <= byte_in[7];
      addr_q <= byte_in[6:0];
      sel_q <= (byte_in[6:0] == QUEUE_ADDR);
    end else if (byte_end && st_q == sxp_pkg::SXP_D_DATA && !sel_q) begin
      addr_q <= addr_q + 7'h01;
    end
  end

  // Write side of a data byte: register, status or queue.
  assign spi_push = byte_end & (st_q == sxp_pkg::SXP_D_DATA) & wnr_q & sel_q;
  assign clr = byte_end & (st_q == sxp_pkg::SXP_D_DATA) & wnr_q & ~sel_q &
               (addr_q == `SXP_STATUS_ADDR) & byte_in[`SXP_ST_OVF_BIT];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 128; i++) begin
        regs[i] <= `SXP_REG_RESET;
      end
    end else if (byte_end && st_q == sxp_pkg::SXP_D_DATA && wnr_q && !sel_q &&
                 addr_q != `SXP_STATUS_ADDR) begin
      regs[addr_q] <= byte_in;
    end
  end

  // Read value; the status byte shows live full and overflow state, and has-bytes as of frame open.
  always_comb begin
    rd_val = regs[addr_q];
    if (addr_q == `SXP_STATUS_ADDR) begin
      rd_val = 8'h00;
      rd_val[`SXP_ST_FULL_BIT] = ~q_ready;
      rd_val[`SXP_ST_HAS_BYTES_BIT] = has_q;
      rd_val[`SXP_ST_OVF_BIT] = ovf_q;
    end
  end

  // Output shift: the next byte is loaded on the fall after a byte ends,
  // so a write returns the content from before the write.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || nss_fall) begin
      out_q <= 8'h00;
      rd_ok_q <= 1'b0;
    end else if (fall && bit_q == 3'h0 && st_q == sxp_pkg::SXP_D_DATA) begin
      out_q <= sel_q ? (q_valid ? q_head : 8'h00) : rd_val;
      rd_ok_q <= sel_q & q_valid;
    end else if (fall) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // The queue pop waits for the first rise of the byte, so the
  // trailing fall before the select rises does not waste a byte.
  assign spi_pop = rise & (bit_q == 3'h0) & (st_q == sxp_pkg::SXP_D_DATA) &
                   sel_q & ~wnr_q & rd_ok_q;

  assign bus.miso_o = out_q[7];
  assign bus.miso_oe = ~nss_s;

  // ========================================================
  // Queue with host and shifter on both sides. The host wins a
  // same-cycle write; the shifter byte then counts as lost.
  // The shifter byte includes the bit arriving in the same cycle as the push.
  assign q_wdata = spi_push ? byte_in : {rx_sh_q[6:0], i_demod_bit};
  assign q_pop = spi_pop | tx_pop;

  sxp_fifo #(.W(`SXP_QUEUE_WIDTH), .D(`SXP_QUEUE_DEPTH)) u_fifo (
    .i_clk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clr(clr),
    .i_in_valid(spi_push | rx_push),
    .i_in_data(q_wdata),
    .o_in_ready(q_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_head),
    .i_out_ready(q_pop)
  );

  // Overflow flag: a lost write sets it, and setting beats clearing.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ovf_q <= 1'b0;
    end else if ((spi_push | rx_push) & (~q_ready | (spi_push & rx_push))) begin
      ovf_q <= 1'b1;
    end else if (clr) begin
      ovf_q <= 1'b0;
    end
  end

  // Has-bytes view only refreshes when a frame opens.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      has_q <= 1'b0;
    end else if (nss_fall) begin
      has_q <= q_valid;
    end
  end

  assign o_queue_has_bytes = has_q;
  assign o_queue_overflow_flag = ovf_q;
  assign o_queue_full = ~q_ready;

  // ========================================================
  // Payload length guard per packet.
  always_comb begin
    case (sxp_pkg::sxp_len_mode_t'(i_len_mode))
      sxp_pkg::SXP_LEN_QUEUE: lim_hit = (pay_q >= `SXP_LIMIT_QUEUE);
      sxp_pkg::SXP_LEN_255: lim_hit = (pay_q >= `SXP_LIMIT_MAX);
      default: lim_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || i_pkt_start) begin
      pay_q <= 9'h000;
    end else if ((tx_pop || rx_push) && pay_q != 9'h1FF) begin
      pay_q <= pay_q + 9'h001;
    end
  end

  // Transmit shifter: loads a byte when empty, sends one bit a tick.
  assign tx_pop = i_tx_en & ~i_cont_mode & (tx_left_q == 4'h0) & q_valid & ~lim_hit &
                  ~spi_pop;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      tx_sh_q <= 8'h00;
      tx_left_q <= 4'h0;
      o_mod_bit <= 1'b0;
    end else if (i_tx_en && i_cont_mode) begin
      if (i_bit_tick) o_mod_bit <= i_serial_data_pin;
    end else if (tx_pop) begin
      tx_sh_q <= q_head;
      tx_left_q <= 4'h8;
    end else if (i_bit_tick && tx_left_q != 4'h0) begin
      o_mod_bit <= tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      tx_left_q <= tx_left_q - 4'h1;
    end
  end

  // Receive shifter: packs demodulated bits, pushes each full byte.
  assign rx_push = i_rx_en & ~i_cont_mode & i_demod_valid & (rx_cnt_q == 3'h7) &
                   ~lim_hit;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_rx_en) begin
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 3'h0;
      o_serial_data_pin <= 1'b0;
    end else if (i_cont_mode) begin
      if (i_demod_valid) o_serial_data_pin <= i_demod_bit;
    end else if (i_demod_valid) begin
      rx_sh_q <= {rx_sh_q[6:0], i_demod_bit};
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- hdl/sxp_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxp_map.svh"

// ==========================================================
// Host end: serial master that makes the link clock itself
module sxp_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Serial link
  sxp_if.host bus,
  // Request
  input wire logic i_start,
  input wire logic i_wnr,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_len,
  // Write data, taken one byte per pulse of o_wready
  input wire logic [7:0] i_wdata,
  output logic o_wready,
  // Read data and status
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_busy
);
  sxp_pkg::sxp_host_st_t st_q;
  logic [3:0] div_q;
  logic tick, sck_q, nss_q, first_q, miso_m, miso_s;
  logic [2:0] bit_q;
  logic [7:0] left_q, tx_q, rx_q;

  // Read line sampled through two flops; the half period leaves room.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      {miso_m, miso_s} <= 2'h3;
    end else begin
      {miso_m, miso_s} <= {bus.miso, miso_m};
    end
  end

  // Divider making the half periods of the link clock.
  assign tick = (div_q == `SXP_SCK_HALF - 4'h1);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || st_q == sxp_pkg::SXP_H_IDLE || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Frame engine: clock idles low, data changes on falls and when select falls.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_q <= sxp_pkg::SXP_H_IDLE;
      sck_q <= 1'b0;
      nss_q <= 1'b1;
      first_q <= 1'b0;
      bit_q <= 3'h0;
      left_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      o_wready <= 1'b0;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_wready <= 1'b0;
      o_rvalid <= 1'b0;
      case (st_q)
        sxp_pkg::SXP_H_IDLE: begin
          if (i_start) begin
            nss_q <= 1'b0;
            tx_q <= {i_wnr, i_addr};
            left_q <= i_len;
            first_q <= 1'b1;
            bit_q <= 3'h0;
            st_q <= sxp_pkg::SXP_H_RUN;
          end
        end
        sxp_pkg::SXP_H_RUN: begin
          if (tick && !sck_q) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[6:0], miso_s};
            bit_q <= bit_q + 3'h1;
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bit_q == 3'h0) begin
              o_rdata <= rx_q;
              o_rvalid <= ~first_q;
              first_q <= 1'b0;
              if (left_q == 8'h00) begin
                st_q <= sxp_pkg::SXP_H_END;
              end else begin
                tx_q <= i_wdata;
                o_wready <= 1'b1;
                left_q <= left_q - 8'h01;
              end
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        sxp_pkg::SXP_H_END: begin
          // Select is held high a full half period before a new frame.
          if (tick && nss_q) st_q <= sxp_pkg::SXP_H_IDLE;
          else if (tick) nss_q <= 1'b1;
        end
        default: st_q <= sxp_pkg::SXP_H_IDLE;
      endcase
    end
  end

  assign bus.sck = sck_q;
  assign bus.nss_b = nss_q;
  assign bus.mosi = tx_q[7];
  assign o_busy = (st_q != sxp_pkg::SXP_H_IDLE);
endmodule
`default_nettype wire

//--- verif/sxp_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link protocol checker, placed beside the link interface
module sxp_chk (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Link wires
  input wire logic sck,
  input wire logic nss_b,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic sck_q;
  logic [2:0] rises_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // Delayed link clock, used to find its rising edges.
  always_ff @(posedge i_mclk) begin
    sck_q <= sck;
  end

  // Rises within one frame; a frame must carry whole bytes only.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || nss_b) begin
      rises_q <= 3'h0;
    end else if (sck && !sck_q) begin
      rises_q <= rises_q + 3'h1;
    end
  end

  // The high half of the link clock lasts exactly eight system clocks.
  sequence s_half_high;
    sck [*8] ##1 !sck;
  endsequence

  AST_HIZ_IDLE: assert property (nss_b [*4] |-> !miso_oe)
    else $error("device drives its output while deselected");
  AST_OE_SELECTED: assert property (!nss_b [*4] |-> miso_oe)
    else $error("device output not driven while selected");
  AST_FIRST_EDGE: assert property ($fell(nss_b) |-> !sck [*4])
    else $error("link clock rose too soon after select fell");
  AST_IDLE_LOW: assert property (nss_b |-> !sck)
    else $error("link clock high outside a frame");
  AST_SCK_HALF: assert property ($rose(sck) |-> s_half_high)
    else $error("link clock high phase has the wrong length");
  AST_MOSI_ON_FALL: assert property (
    (!nss_b && $changed(mosi)) |-> ($fell(sck) || $fell(nss_b)))
    else $error("host data changed away from a falling link edge");
  AST_MISO_CHANGE_LOW: assert property (($changed(miso_o) && miso_oe) |-> !sck)
    else $error("device data changed while link clock high");
  AST_WHOLE_BYTES: assert property ($rose(nss_b) |-> rises_q == 3'h0)
    else $error("frame ended on a partial byte");
endmodule
`default_nettype wire

//--- verif/spi_register_fifo_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxp_map.svh"
// ==========================================
// Bench: host end and device end joined by the link interface
module spi_register_fifo_port_tb;
  logic i_mclk;
  logic i_rst_b;
  logic i_start;
  logic i_wnr;
  logic [6:0] i_addr;
  logic [7:0] i_len;
  logic [7:0] i_wdata;
  logic o_wready;
  logic [7:0] o_rdata;
  logic o_rvalid;
  logic o_busy;
  logic rx_en;
  logic pkt_start;
  logic dv;
  logic db;
  logic [1:0] len_mode;
  logic has_b;
  logic ovf;
  logic full;
  logic [7:0] rxb;
  logic tx_en;
  logic cont;
  logic tick;
  logic sdi;
  logic mod_bit;
  logic sdo;
  logic [7:0] wbuf [0:79];
  logic [7:0] rbuf [0:79];
  int fails;
  int checks;

  sxp_if u_sxp_if ();
  sxp_host u_sxp_host (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .bus(u_sxp_if), .i_start(i_start),
    .i_wnr(i_wnr), .i_addr(i_addr), .i_len(i_len), .i_wdata(i_wdata), .o_wready(o_wready),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy(o_busy));
  sxp_dev u_sxp_dev (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .bus(u_sxp_if), .i_tx_en(tx_en),
    .i_rx_en(rx_en), .i_cont_mode(cont), .i_bit_tick(tick), .i_demod_valid(dv),
    .i_demod_bit(db), .i_serial_data_pin(sdi), .i_pkt_start(pkt_start),
    .i_len_mode(len_mode), .o_mod_bit(mod_bit), .o_serial_data_pin(sdo),
    .o_queue_has_bytes(has_b), .o_queue_overflow_flag(ovf), .o_queue_full(full));
  sxp_chk u_sxp_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .sck(u_sxp_if.sck),
    .nss_b(u_sxp_if.nss_b), .mosi(u_sxp_if.mosi), .miso_o(u_sxp_if.miso_o),
    .miso_oe(u_sxp_if.miso_oe));

  // Free-running system clock.
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d fails", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One frame; write bytes come from wbuf, returned bytes land in rbuf.
  // The command bits are caught off the wire, so a host fault shows too.
  task automatic xfer(input logic wnr, input logic [6:0] addr, input int n);
    int k;
    int r;
    int t;
    logic [7:0] cmd;
    logic sck_p;
    k = 0;
    r = 0;
    t = 0;
    cmd = 8'h00;
    sck_p = 1'b0;
    i_wnr = wnr;
    i_addr = addr;
    i_len = n[7:0];
    i_wdata = wbuf[0];
    i_start = 1'b1;
    @(posedge i_mclk);
    #1 i_start = 1'b0;
    do begin
      @(posedge i_mclk);
      t++;
      if (u_sxp_if.sck && !sck_p && t < 130) begin
        cmd = {cmd[6:0], u_sxp_if.mosi};
      end
      sck_p = u_sxp_if.sck;
      if (o_rvalid === 1'b1) begin
        rbuf[r % 80] = o_rdata;
        r++;
      end
      if (o_wready === 1'b1) begin
        k++;
      end
      #1 i_wdata = wbuf[k % 80];
    end while (o_busy === 1'b1 && t < 300 * n + 400);
    if (o_busy !== 1'b0) begin
      fails++;
      wrap_up();
    end
    check("command bits", cmd, {wnr, addr});
    check("byte count", r[7:0], n[7:0]);
  endtask

  // Main sequence.
  initial begin
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_wnr = 1'b0;
    i_addr = 7'h00;
    i_len = 8'h00;
    i_wdata = 8'h00;
    rx_en = 1'b0;
    pkt_start = 1'b0;
    dv = 1'b0;
    db = 1'b0;
    len_mode = 2'h2;
    rxb = 8'h6D;
    tx_en = 1'b0;
    cont = 1'b0;
    tick = 1'b0;
    sdi = 1'b0;
    fails = 0;
    checks = 0;
    repeat (20) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    check("idle line", {7'h00, u_sxp_if.miso}, 8'h01);
    for (int i = 0; i < 4; i++) wbuf[i] = 8'hA1 + 8'(i) * 8'h11;
    xfer(1'b1, 7'h10, 4);
    for (int i = 0; i < 4; i++) check("old value", rbuf[i], 8'h00);
    xfer(1'b0, 7'h10, 4);
    for (int i = 0; i < 4; i++) check("burst read", rbuf[i], wbuf[i]);
    wbuf[0] = 8'h5C;
    xfer(1'b1, 7'h12, 1);
    check("single write old", rbuf[0], 8'hC3);
    xfer(1'b0, 7'h11, 1);
    check("fresh address", rbuf[0], 8'hB2);
    xfer(1'b0, 7'h12, 1);
    check("single read", rbuf[0], 8'h5C);
    $display("Test registers done");
    // Queue frames keep their address; an empty queue reads as zero.
    for (int i = 0; i < 80; i++) wbuf[i] = 8'(i) + 8'h30;
    xfer(1'b1, `SXP_QUEUE_ADDR, 3);
    check("queue write return", rbuf[0], 8'h00);
    xfer(1'b0, `SXP_STATUS_ADDR, 1);
    check("status has bytes", rbuf[0], 8'h40);
    xfer(1'b0, `SXP_QUEUE_ADDR, 4);
    for (int i = 0; i < 3; i++) check("queue read", rbuf[i], wbuf[i]);
    check("queue empty read", rbuf[3], 8'h00);
    xfer(1'b0, `SXP_STATUS_ADDR, 1);
    check("status drained", rbuf[0], 8'h00);
    check("has bytes pin", {7'h00, has_b}, 8'h00);
    $display("Test queue access done");
    // Fill to the boundary, overflow, then clear through the status byte.
    xfer(1'b1, `SXP_QUEUE_ADDR, 65);
    check("not yet full", {7'h00, full}, 8'h00);
    xfer(1'b1, `SXP_QUEUE_ADDR, 1);
    check("full flag", {7'h00, full}, 8'h01);
    xfer(1'b1, `SXP_QUEUE_ADDR, 1);
    check("overflow flag", {7'h00, ovf}, 8'h01);
    wbuf[0] = 8'h10;
    xfer(1'b1, `SXP_STATUS_ADDR, 1);
    check("status before clear", rbuf[0], 8'hD0);
    xfer(1'b0, `SXP_STATUS_ADDR, 1);
    check("status after clear", rbuf[0], 8'h00);
    check("overflow cleared", {7'h00, ovf}, 8'h00);
    $display("Test queue overflow done");
    // Demodulated bits arrive most significant first and are packed.
    rx_en = 1'b1;
    pkt_start = 1'b1;
    @(posedge i_mclk);
    #1 pkt_start = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      db = rxb[i];
      dv = 1'b1;
      @(posedge i_mclk);
      #1 dv = 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
    end
    rx_en = 1'b0;
    // Leaving receive, the queue is left alone for a few cycles first.
    repeat (4) @(posedge i_mclk);
    #1;
    xfer(1'b0, `SXP_QUEUE_ADDR, 1);
    check("received byte", rbuf[0], rxb);
    $display("Test receive shifter done");
    // Transmit: the shifter takes the queued byte and sends it MSB first.
    wbuf[0] = 8'h9A;
    xfer(1'b1, `SXP_QUEUE_ADDR, 1);
    tx_en = 1'b1;
    repeat (2) @(posedge i_mclk);
    for (int i = 7; i >= 0; i--) begin
      #1 tick = 1'b1;
      @(posedge i_mclk);
      #1 tick = 1'b0;
      check("modulator bit", {7'h00, mod_bit}, {7'h00, wbuf[0][i]});
      @(posedge i_mclk);
    end
    $display("Test transmit shifter done");
    // Continuous mode: bits pass straight through in both directions.
    #1 cont = 1'b1;
    rx_en = 1'b1;
    for (int i = 1; i >= 0; i--) begin
      sdi = i[0];
      db = i[0];
      tick = 1'b1;
      dv = 1'b1;
      @(posedge i_mclk);
      #1 tick = 1'b0;
      dv = 1'b0;
      check("live transmit bit", {7'h00, mod_bit}, {7'h00, i[0]});
      check("live receive bit", {7'h00, sdo}, {7'h00, i[0]});
    end
    $display("Test continuous mode done");
    // A queue-sized payload limit stops the shifter before it overruns.
    cont = 1'b0;
    tx_en = 1'b0;
    len_mode = 2'h0;
    pkt_start = 1'b1;
    @(posedge i_mclk);
    #1 pkt_start = 1'b0;
    dv = 1'b1;
    repeat (536) @(posedge i_mclk);
    #1 dv = 1'b0;
    check("limit stops overrun", {7'h00, ovf}, 8'h00);
    check("limit fills queue", {7'h00, full}, 8'h01);
    $display("Test payload limit done");
    wrap_up();
  end

  // Guard against a hang anywhere in the run.
  initial begin
    repeat (60000) @(posedge i_mclk);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
